// *** src/gpe_ports.sv ***
// Top of the port E..H general-purpose I/O block with AXI4-Lite access.
// Assumes pins and peripheral signals are synchronous to core_clk.
//
// Functional notes
// - Serial unit disabled releases port E pins 1 and 0 to GPIO.
// - Serial-owned port E pins ignore direction for drive, not for reads.
// - Port E direction one enables output buffer, zero makes input.
// - Reset clears all port E direction bits.
// - Port E read gives latch where output, pin where input.
// - Latches accept writes regardless of direction; inputs unaffected.
// - Port F seven latches read/write, untouched by reset.
// - Port F pins 3..0 go to timer A channels when selected.
// - Port F pins 5..4 go to timer B channels when selected.
// - Timer-owned port F pins ignore direction for drive, not reads.
// - Port F read gives latch where output, pin where input.
// - Reset clears the seven port F direction bits.
// - Port G three latches read/write, untouched by reset.
// - Key interrupt enable overrides port G direction to input for drive, not for reads.
// - Port G read gives latch where output, pin where input.
// - Reset clears the three port G direction bits.
// - Key interrupt enables 4 and 3 override port H direction to input for drive, not for reads.
// - Port H read gives latch where output, pin where input.
// - Reset clears both port H direction bits.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module gpe_ports (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_b,
    // AXI4-Lite write
    input  wire logic [31:0]             awaddr,
    input  wire logic                    awvalid,
    output      logic                    awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output      logic                    wready,
    output      logic [1:0]              bresp,
    output      logic                    bvalid,
    input  wire logic                    bready,
    // AXI4-Lite read
    input  wire logic [31:0]             araddr,
    input  wire logic                    arvalid,
    output      logic                    arready,
    output      logic [31:0]             rdata,
    output      logic [1:0]              rresp,
    output      logic                    rvalid,
    input  wire logic                    rready,
    // Peripheral drive, one bit per pin of E,F,G,H concatenated
    input  wire logic [19:0]             per_out,
    input  wire logic [19:0]             per_oe,
    // Pins, concatenated H,G,F,E from high to low
    input  wire logic [19:0]             pin_in,
    output      logic [19:0]             pin_out,
    output      logic [19:0]             pin_oe,
    // Current ownership controls, mirrored for peripherals
    output      gpe_pkg::gpe_owner_t     owner
);
    localparam int NPIN = gpe_pkg::W_E + gpe_pkg::W_F
                        + gpe_pkg::W_G + gpe_pkg::W_H;

    // Register side strobes
    logic        wr_en;
    logic [7:0]  wr_idx;
    logic [7:0]  wr_data;
    logic [7:0]  rd_idx;
    logic [7:0]  rd_val;
    logic        wr_ok;
    logic        rd_ok;

    // Storage
    logic [NPIN-1:0] latch;
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] owned;
    logic [NPIN-1:0] next_out;
    logic [NPIN-1:0] next_oe;
    logic [NPIN-1:0] rd_bits;
    logic [7:0]      owner_byte;
    logic [4:0]      key_bits;
    gpe_pkg::gpe_owner_t next_owner;

    // Index decoding used by both read and write paths
    function automatic logic known_idx(input logic [7:0] idx);
        known_idx = (idx >= gpe_pkg::IDX_E_LATCH) &&
                    (idx <= gpe_pkg::IDX_KEY);
    endfunction : known_idx

    assign wr_ok = known_idx(wr_idx);
    assign rd_ok = known_idx(rd_idx);

    gpe_axi u_axi (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .awaddr   (awaddr),
        .awvalid  (awvalid),
        .awready  (awready),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .wvalid   (wvalid),
        .wready   (wready),
        .bresp    (bresp),
        .bvalid   (bvalid),
        .bready   (bready),
        .araddr   (araddr),
        .arvalid  (arvalid),
        .arready  (arready),
        .rdata    (rdata),
        .rresp    (rresp),
        .rvalid   (rvalid),
        .rready   (rready),
        .wr_en    (wr_en),
        .wr_idx   (wr_idx),
        .wr_data  (wr_data),
        .wr_ok    (wr_ok),
        .rd_idx   (rd_idx),
        .rd_val   (rd_val),
        .rd_ok    (rd_ok)
    );

    // Write strobes per register
    wire we_el = wr_en && (wr_idx == gpe_pkg::IDX_E_LATCH);
    wire we_fl = wr_en && (wr_idx == gpe_pkg::IDX_F_LATCH);
    wire we_gl = wr_en && (wr_idx == gpe_pkg::IDX_G_LATCH);
    wire we_hl = wr_en && (wr_idx == gpe_pkg::IDX_H_LATCH);
    wire we_ed = wr_en && (wr_idx == gpe_pkg::IDX_E_DIR);
    wire we_fd = wr_en && (wr_idx == gpe_pkg::IDX_F_DIR);
    wire we_gd = wr_en && (wr_idx == gpe_pkg::IDX_G_DIR);
    wire we_hd = wr_en && (wr_idx == gpe_pkg::IDX_H_DIR);
    wire we_ow = wr_en && (wr_idx == gpe_pkg::IDX_OWNER);
    wire we_ky = wr_en && (wr_idx == gpe_pkg::IDX_KEY);

    // Data latches have no reset; writes land whatever the direction
    always_ff @(posedge core_clk) begin
        if (we_el) latch[7:0]   <= wr_data;
        if (we_fl) latch[14:8]  <= wr_data[6:0];
        if (we_gl) latch[17:15] <= wr_data[2:0];
        if (we_hl) latch[19:18] <= wr_data[1:0];
    end

    // Direction registers clear at reset, all pins inputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dir[7:0]   <= gpe_pkg::DIR_RST;
            dir[14:8]  <= gpe_pkg::DIR_RST[6:0];
            dir[17:15] <= gpe_pkg::DIR_RST[2:0];
            dir[19:18] <= gpe_pkg::DIR_RST[1:0];
        end else begin
            if (we_ed) dir[7:0]   <= wr_data;
            if (we_fd) dir[14:8]  <= wr_data[6:0];
            if (we_gd) dir[17:15] <= wr_data[2:0];
            if (we_hd) dir[19:18] <= wr_data[1:0];
        end
    end

    // Ownership controls: serial enable, timer selects, key enables
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            owner_byte <= gpe_pkg::DIR_RST;
            key_bits   <= gpe_pkg::DIR_RST[4:0];
        end else begin
            if (we_ow) owner_byte <= wr_data;
            if (we_ky) key_bits   <= wr_data[4:0];
        end
    end

    // Unpack the control bytes; key enables need a byte of their own
    assign next_owner.serial_iface_enable =
                        owner_byte[gpe_pkg::OWN_SER_BIT];
    assign next_owner.timer_a_sel =
                        owner_byte[gpe_pkg::OWN_TA_LSB +: gpe_pkg::TA_W];
    assign next_owner.timer_b_sel =
                        owner_byte[gpe_pkg::OWN_TB_LSB +: gpe_pkg::TB_W];
    assign next_owner.key_irq_enable = key_bits;

    // Which pins a peripheral has taken
    wire ser_en = owner.serial_iface_enable;
    assign owned[gpe_pkg::SER_TX_BIT] = ser_en;
    assign owned[gpe_pkg::SER_RX_BIT] = ser_en;
    assign owned[7:2]   = 6'h00;
    assign owned[8 + gpe_pkg::TA_LSB +: gpe_pkg::TA_W]
                        = owner.timer_a_sel;
    assign owned[8 + gpe_pkg::TB_LSB +: gpe_pkg::TB_W]
                        = owner.timer_b_sel;
    assign owned[14]    = 1'b0;
    assign owned[17:15] = owner.key_irq_enable[2:0];
    assign owned[19:18] = owner.key_irq_enable[4:3];

    // Per-pin steering; key pins force an undriven input
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            wire key_pin = (gi >= 15);
            gpe_pin u_pin (
                .latch    (latch[gi]),
                .dir      (dir[gi]),
                .owned    (owned[gi]),
                .per_out  (key_pin ? 1'b0 : per_out[gi]),
                .per_oe   (key_pin ? 1'b0 : per_oe[gi]),
                .pin_in   (pin_in[gi]),
                .next_out (next_out[gi]),
                .next_oe  (next_oe[gi]),
                .rd_bit   (rd_bits[gi])
            );
        end
    endgenerate

    // Register the pad drive so outputs come from flip-flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 20'h0_0000;
            pin_oe  <= 20'h0_0000;
            owner   <= '0;
        end else begin
            pin_out <= next_out;
            pin_oe  <= next_oe;
            owner   <= next_owner;
        end
    end

    // Read selection by index; direction picks latch or pin
    assign rd_val =
        (rd_idx == gpe_pkg::IDX_E_LATCH) ? rd_bits[7:0] :
        (rd_idx == gpe_pkg::IDX_F_LATCH) ? {1'b0, rd_bits[14:8]} :
        (rd_idx == gpe_pkg::IDX_G_LATCH) ? {5'h00, rd_bits[17:15]} :
        (rd_idx == gpe_pkg::IDX_H_LATCH) ? {6'h00, rd_bits[19:18]} :
        (rd_idx == gpe_pkg::IDX_E_DIR)   ? dir[7:0] :
        (rd_idx == gpe_pkg::IDX_F_DIR)   ? {1'b0, dir[14:8]} :
        (rd_idx == gpe_pkg::IDX_G_DIR)   ? {5'h00, dir[17:15]} :
        (rd_idx == gpe_pkg::IDX_H_DIR)   ? {6'h00, dir[19:18]} :
        (rd_idx == gpe_pkg::IDX_OWNER)   ? owner_byte :
        (rd_idx == gpe_pkg::IDX_KEY)     ? {3'h0, key_bits} : 8'h00;

endmodule : gpe_ports

// *** src/gpe_pkg.sv ***
// Package for the port E..H general-purpose I/O block.
// Assumes a 32-bit AXI4-Lite register bus and a single core clock.
package gpe_pkg;

    // Printed register indices; byte address is four times the index
    localparam logic [7:0] IDX_E_LATCH = 8'h08;
    localparam logic [7:0] IDX_F_LATCH = 8'h09;
    localparam logic [7:0] IDX_G_LATCH = 8'h0a;
    localparam logic [7:0] IDX_H_LATCH = 8'h0b;
    // Chosen indices for direction and ownership registers
    localparam logic [7:0] IDX_E_DIR   = 8'h0c;
    localparam logic [7:0] IDX_F_DIR   = 8'h0d;
    localparam logic [7:0] IDX_G_DIR   = 8'h0e;
    localparam logic [7:0] IDX_H_DIR   = 8'h0f;
    localparam logic [7:0] IDX_OWNER   = 8'h10;
    localparam logic [7:0] IDX_KEY     = 8'h11;

    // Port widths
    localparam int W_E = 8;
    localparam int W_F = 7;
    localparam int W_G = 3;
    localparam int W_H = 2;

    // Field positions
    localparam int SER_RX_BIT = 1;
    localparam int SER_TX_BIT = 0;
    localparam int TA_LSB     = 0;
    localparam int TA_W       = 4;
    localparam int TB_LSB     = 4;
    localparam int TB_W       = 2;
    localparam int KBG_LSB    = 0;
    localparam int KBH_LSB    = 3;
    // Control fields in the ownership byte
    localparam int OWN_SER_BIT = 0;
    localparam int OWN_TA_LSB  = 1;
    localparam int OWN_TB_LSB  = 5;

    // Reset values
    localparam logic [7:0]  DIR_RST   = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Peripheral ownership controls gathered together
    typedef struct packed {
        logic       serial_iface_enable;
        logic [3:0] timer_a_sel;   // Channel edge_level_select nonzero
        logic [1:0] timer_b_sel;
        logic [4:0] key_irq_enable;
    } gpe_owner_t;

endpackage : gpe_pkg

// *** src/gpe_pin.sv ***
// One GPIO pin slice: buffer steering and read-back selection.
// Assumes pin_in is synchronous to the clock of the reader.
`timescale 1ns/1ns
module gpe_pin (
    // Software state
    input  wire logic latch,
    input  wire logic dir,
    // Peripheral takeover
    input  wire logic owned,
    input  wire logic per_out,
    input  wire logic per_oe,
    // Pin
    input  wire logic pin_in,
    output      logic next_out,
    output      logic next_oe,
    output      logic rd_bit
);
    // Owner drives the buffer; direction still picks read source
    assign next_out = owned ? per_out : latch;
    assign next_oe  = owned ? per_oe  : dir;
    assign rd_bit   = dir ? latch : pin_in;
endmodule : gpe_pin

// *** src/gpe_axi.sv ***
// AXI4-Lite slave front end producing one-cycle register strobes.
// Assumes the master follows AXI4-Lite handshakes; one access each way.
`timescale 1ns/1ns
module gpe_axi (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Write channels
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    // Read channels
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    // Register side
    output      logic        wr_en,
    output      logic [7:0]  wr_idx,
    output      logic [7:0]  wr_data,
    input  wire logic        wr_ok,
    output      logic [7:0]  rd_idx,
    input  wire logic [7:0]  rd_val,
    input  wire logic        rd_ok
);
    logic        aw_have;
    logic        w_have;
    logic [7:0]  aw_idx;
    logic [7:0]  w_byte;
    logic        w_lane;

    // Write fires when both halves are held and no response pends
    assign wr_en   = aw_have & w_have & ~bvalid;
    assign wr_idx  = aw_idx;
    assign wr_data = w_byte;
    assign rd_idx  = araddr[9:2];

    // Capture address and data separately, in either order
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            aw_idx  <= 8'h00;
            w_byte  <= 8'h00;
            w_lane  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= gpe_pkg::RESP_OKAY;
        end else begin
            awready <= ~aw_have & ~awready & awvalid;
            wready  <= ~w_have & ~wready & wvalid;
            if (awvalid && awready) begin
                aw_have <= 1'b1;
                aw_idx  <= awaddr[9:2];
            end
            if (wvalid && wready) begin
                w_have <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane <= wstrb[0];
            end
            if (wr_en) begin
                aw_have <= 1'b0;
                w_have  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (wr_ok && w_lane) ? gpe_pkg::RESP_OKAY
                                             : gpe_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read answers one cycle after the address is taken
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= gpe_pkg::RDATA_RST;
            rresp   <= gpe_pkg::RESP_OKAY;
        end else begin
            arready <= ~arready & ~rvalid & arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= {24'h00_0000, rd_val};
                rresp  <= rd_ok ? gpe_pkg::RESP_OKAY : gpe_pkg::RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule : gpe_axi

// *** bench/gpe_ports_props.sv ***
// Checker for the port block: bus timing and pad takeover.
// Assumes it is bound to gpe_ports and sees its ports only.
`timescale 1ns/1ns
module gpe_ports_props (
    // Clock and reset
    input wire logic                core_clk,
    input wire logic                rst_b,
    // Bus
    input wire logic                awvalid,
    input wire logic                awready,
    input wire logic [1:0]          bresp,
    input wire logic                bvalid,
    input wire logic                bready,
    input wire logic                arvalid,
    input wire logic                arready,
    input wire logic [31:0]         rdata,
    input wire logic                rvalid,
    input wire logic                rready,
    // Pads
    input wire logic [19:0]         per_out,
    input wire logic [19:0]         per_oe,
    input wire logic [19:0]         pin_out,
    input wire logic [19:0]         pin_oe,
    input wire gpe_pkg::gpe_owner_t owner
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Answers come in time and stand until taken
    AST_B_TIME: assert property (awvalid && awready |-> ##[1:4] bvalid)
        else $error("No write response");
    AST_R_TIME: assert property (arvalid && arready |-> ##[1:3] rvalid)
        else $error("No read response");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("Read data dropped");
    // Pads start undriven
    AST_RST_IN: assert property (
        $rose(rst_b) |-> pin_oe == 20'h0)
        else $error("Pad driven after reset");
    // Owned serial pads follow the peripheral one cycle later; owned timer pads follow its enable only
    AST_SER_OWN: assert property (
        owner.serial_iface_enable && $past(owner.serial_iface_enable) |->
        pin_oe[1:0] == $past(per_oe[1:0])
        && pin_out[1:0] == $past(per_out[1:0]))
        else $error("Serial pads not lent");
    AST_TA_OWN: assert property (
        ((pin_oe[11:8] ^ $past(per_oe[11:8])) & owner.timer_a_sel
        & $past(owner.timer_a_sel)) == 4'h0)
        else $error("Timer A pads not lent");
    AST_TB_OWN: assert property (
        ((pin_oe[13:12] ^ $past(per_oe[13:12])) & owner.timer_b_sel
        & $past(owner.timer_b_sel)) == 2'h0)
        else $error("Timer B pads not lent");
    // Key interrupt pads are undriven from the cycle after their key enable is set
    AST_KEY_IN: assert property (
        (pin_oe[19:15] & owner.key_irq_enable
        & $past(owner.key_irq_enable)) == 5'h0)
        else $error("Key pad driven");
endmodule : gpe_ports_props

bind gpe_ports gpe_ports_props u_props (
    .core_clk(core_clk), .rst_b(rst_b), .awvalid(awvalid),
    .awready(awready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .per_out(per_out), .per_oe(per_oe),
    .pin_out(pin_out), .pin_oe(pin_oe), .owner(owner));

// *** bench/gpe_pads.sv ***
// Model of the pads and the world beyond them.
// Assumes one bit per pin, H,G,F,E from high to low.
`timescale 1ns/1ns
module gpe_pads (
    // Drive from the block
    input  wire logic [19:0] pin_out,
    input  wire logic [19:0] pin_oe,
    // Outside level on undriven pads
    input  wire logic [19:0] ext,
    // Level seen back
    output      logic [19:0] pin_in
);
    // Driven pads read their own drive
    assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : gpe_pads

// *** bench/gpe_ports_tb.sv ***
// Self-checking bench for the port block over AXI4-Lite.
// Assumes gpe_pads and the bound checker are compiled alongside.
`timescale 1ns/1ns
module gpe_ports_tb;
    logic        core_clk, rst_b, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [19:0] per_out, per_oe, pin_in, pin_out, pin_oe, ext;
    logic [7:0]  lat[4], dir[4];
    gpe_pkg::gpe_owner_t own;
    int          errors, n_checks, cyc;
    int          lsb[4] = '{0, 8, 15, 18};
    int          wid[4] = '{8, 7, 3, 2};

    gpe_ports dut (.core_clk(core_clk), .rst_b(rst_b), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .per_out(per_out), .per_oe(per_oe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .owner(own));
    gpe_pads u_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
        .pin_in(pin_in));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Expected values
    function automatic logic [7:0] msk(input int p);
        return 8'((1 << wid[p]) - 1);
    endfunction : msk
    function automatic logic [31:0] f_rd(input int p, input logic [7:0] l, d);
        logic [7:0] x;
        x = 8'(ext >> lsb[p]);
        return {24'h0, ((l & d) | (x & ~d)) & msk(p)};
    endfunction : f_rd
    function automatic logic [19:0] cat(input logic [7:0] a[4]);
        return {a[3][1:0], a[2][2:0], a[1][6:0], a[0]};
    endfunction : cat

    // Comparisons
    task automatic chk_d(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_d
    task automatic chk_p(input logic [19:0] g, e);
        chk_d({12'h0, g}, {12'h0, e});
    endtask : chk_p

    // Bus master cycles
    task automatic wr(input logic [7:0] i, d, output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= {22'h0, i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] i, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge core_clk);
        araddr <= {22'h0, i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        {awaddr, wdata, araddr, awvalid, wvalid, bready} = '0;
        {arvalid, rready, per_out, per_oe, ext} = '0;
        wstrb = 4'hf;
        rst_b = 1'b0;
        void'($urandom(32'ha028));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            rdr(gpe_pkg::IDX_E_DIR + 8'(p), rv, rs);
            chk_d(rv, 32'h0);
        end
        $display("Test reset directions done");
        wr(gpe_pkg::IDX_OWNER, 8'h00, rs);
        for (int k = 0; k < 8; k++) begin
            ext <= 20'($urandom);
            for (int p = 0; p < 4; p++) begin
                lat[p] = 8'($urandom);
                dir[p] = (k == 0) ? 8'h0 : (k == 1) ? 8'hff : 8'($urandom);
                dir[p] = dir[p] & msk(p);
                wr(gpe_pkg::IDX_E_LATCH + 8'(p), lat[p], rs);
                wr(gpe_pkg::IDX_E_DIR + 8'(p), dir[p], rs);
            end
            repeat (2) @(posedge core_clk);
            #1;
            chk_p(pin_oe, cat(dir));
            chk_p(pin_out & pin_oe, cat(lat) & cat(dir));
            for (int p = 0; p < 4; p++) begin
                for (int j = 0; j < 2; j++) begin
                    rdr(gpe_pkg::IDX_E_LATCH + 8'(p), rv, rs);
                    chk_d(rv, f_rd(p, lat[p], dir[p]));
                    lat[p] = ~lat[p];
                    wr(gpe_pkg::IDX_E_LATCH + 8'(p), lat[p], rs);
                end
            end
        end
        $display("Test latch and pin reads done");
        rdr(8'h12, rv, rs);
        chk_d({30'h0, rs}, {30'h0, gpe_pkg::RESP_SLVERR});
        wstrb <= 4'he;
        wr(gpe_pkg::IDX_OWNER, 8'h00, rs);
        wstrb <= 4'hf;
        chk_d({30'h0, rs}, {30'h0, gpe_pkg::RESP_SLVERR});
        $display("Test unmapped read done");
        dir[0] = 8'hff;
        dir[1] = 8'h7f;
        dir[2] = 8'h07;
        dir[3] = 8'h03;
        for (int p = 0; p < 4; p++)
            wr(gpe_pkg::IDX_E_DIR + 8'(p), dir[p], rs);
        per_out <= 20'($urandom);
        per_oe <= 20'($urandom);
        wr(gpe_pkg::IDX_OWNER, 8'hff, rs);
        wr(gpe_pkg::IDX_KEY, 8'h1f, rs);
        chk_d({30'h0, rs}, {30'h0, gpe_pkg::RESP_OKAY});
        repeat (3) @(posedge core_clk);
        #1;
        chk_d({20'h0, own}, 32'h0000_0fff);
        chk_p(pin_oe & 20'h03f03, per_oe & 20'h03f03);
        chk_p(pin_oe & 20'hf8000, 20'h0);
        chk_p(pin_out & 20'h03f03, per_out & 20'h03f03);
        for (int p = 0; p < 2; p++) begin
            rdr(gpe_pkg::IDX_E_LATCH + 8'(p), rv, rs);
            chk_d(rv, f_rd(p, lat[p], dir[p]));
        end
        wr(gpe_pkg::IDX_OWNER, 8'h00, rs);
        wr(gpe_pkg::IDX_KEY, 8'h00, rs);
        repeat (2) @(posedge core_clk);
        #1;
        chk_p(pin_oe, cat(dir));
        $display("Test peripheral takeover done");
        @(posedge core_clk);
        per_out <= 20'h0;
        per_oe <= 20'h0;
        rst_b <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int p = 1; p < 4; p++) begin
            wr(gpe_pkg::IDX_E_DIR + 8'(p), 8'hff, rs);
            rdr(gpe_pkg::IDX_E_LATCH + 8'(p), rv, rs);
            chk_d(rv, {24'h0, lat[p] & msk(p)});
        end
        $display("Test latches across reset done");
        wrap_up();
    end
endmodule : gpe_ports_tb
